// file: hw/dcr_regs.sv
`timescale 1ns/1ps
`include "dcr_params.svh"

// Functional notes
// - Code register takes frame bits 19..2.
// - Stored code drives the converter directly.
// - Control fields laid out per fixed bit map.
// - Amplifier bit: 0 powered/series, 1 off/parallel.
// - Clamp bit: 0 normal, 1 clamped/tristated.
// - Reset enters ground-clamp mode.
// - Clamp set overrides tristate bit.
// - Frame is rw, 3-bit address, 20 data.
// - Tristate bit: 0 normal, 1 tristated.
module dcr_regs
(
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 frame_active_i,
  input  wire logic                 bit_valid_i,
  input  wire logic                 bit_data_i,
  output dcr_pkg::dcr_word_t        output_code_o,
  output dcr_pkg::dcr_word_t        mode_control_o,
  output logic [`DCR_CODE_W-1:0]    dac_code_o,
  output logic                      amp_powered_o,
  output logic                      fb_parallel_o,
  output logic                      output_ground_clamp_o,
  output logic                      converter_tristate_o,
  output logic                      code_format_sel_o,
  output logic                      serial_out_disable_o,
  output logic [`DCR_LIN_W-1:0]     lin_comp_o,
  output logic                      write_done_o
);
  import dcr_pkg::*;

  logic                   frame_done;
  logic [`DCR_FRAME_W-1:0] frame_word;
  dcr_word_t              output_code;
  dcr_word_t              mode_control;
  localparam dcr_word_t   CODE_RST = `DCR_CODE_RST;
  localparam dcr_word_t   CTRL_RST = `DCR_CTRL_RST;

  // Framing and bit counting live in the receiver.
  dcr_frame_rx #(
    .FRAME_W (`DCR_FRAME_W)
  ) u_rx (
    .mclk_i         (mclk_i),
    .sys_rst_i      (sys_rst_i),
    .frame_active_i (frame_active_i),
    .bit_valid_i    (bit_valid_i),
    .bit_data_i     (bit_data_i),
    .frame_done_o   (frame_done),
    .frame_word_o   (frame_word)
  );

  // Frame decode: read/write flag, address, data field.
  wire       frame_rd   = frame_word[`DCR_RW_BIT];
  dcr_addr_t frame_addr;
  assign     frame_addr = frame_word[`DCR_ADDR_HI:`DCR_ADDR_LO];
  wire [`DCR_DATA_W-1:0] frame_data = frame_word[`DCR_DATA_HI:`DCR_DATA_LO];
  wire       wr_code    = frame_done && !frame_rd && (frame_addr == `DCR_ADDR_CODE);
  wire       wr_ctrl    = frame_done && !frame_rd && (frame_addr == `DCR_ADDR_CTRL);

  // Only the 18 code bits are kept; the two low bits are dropped on write.
  wire dcr_word_t next_code = {frame_data[`DCR_CODE_HI:`DCR_CODE_LO], 2'h0};

  // Reserved control bits are stored as zero, so a careless host cannot set them.
  dcr_word_t next_ctrl;
  always_comb
  begin
    next_ctrl                                = '0;
    next_ctrl[`DCR_BIT_AMP]                  = frame_data[`DCR_BIT_AMP];
    next_ctrl[`DCR_BIT_CLAMP]                = frame_data[`DCR_BIT_CLAMP];
    next_ctrl[`DCR_BIT_TRI]                  = frame_data[`DCR_BIT_TRI];
    next_ctrl[`DCR_BIT_FMT]                  = frame_data[`DCR_BIT_FMT];
    next_ctrl[`DCR_BIT_SDO]                  = frame_data[`DCR_BIT_SDO];
    next_ctrl[`DCR_LIN_HI:`DCR_LIN_LO]       = frame_data[`DCR_LIN_HI:`DCR_LIN_LO];
  end

  // Registers change only on a good write frame; reset restores the clamp state.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      output_code  <= `DCR_CODE_RST;
      mode_control <= `DCR_CTRL_RST; // Clamp, tristate and parallel set.
      write_done_o <= 1'b0;
    end
    else
    begin
      write_done_o <= wr_code || wr_ctrl;
      if (wr_code)
        output_code <= next_code;
      if (wr_ctrl)
        mode_control <= next_ctrl;
    end
  end

  // Next stored values: a good write replaces the addressed register, anything else holds it.
  dcr_word_t next_output_code;
  dcr_word_t next_mode_control;
  assign next_output_code  = wr_code ? next_code : output_code;
  assign next_mode_control = wr_ctrl ? next_ctrl : mode_control;

  // Field decode of the next control value; clamp forces tristate whatever its own bit says.
  wire next_clamp = next_mode_control[`DCR_BIT_CLAMP];
  wire next_tri   = next_clamp || next_mode_control[`DCR_BIT_TRI];
  wire next_amp   = next_mode_control[`DCR_BIT_AMP];

  // Decoded pins are flopped from the next values, so they move on the same edge as the
  // stored registers and no gate sits between a flop and a pin.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      dac_code_o            <= CODE_RST[`DCR_CODE_HI:`DCR_CODE_LO];
      amp_powered_o         <= !CTRL_RST[`DCR_BIT_AMP];
      fb_parallel_o         <= CTRL_RST[`DCR_BIT_AMP];
      output_ground_clamp_o <= CTRL_RST[`DCR_BIT_CLAMP];
      converter_tristate_o  <= CTRL_RST[`DCR_BIT_CLAMP] || CTRL_RST[`DCR_BIT_TRI];
      code_format_sel_o     <= CTRL_RST[`DCR_BIT_FMT];
      serial_out_disable_o  <= CTRL_RST[`DCR_BIT_SDO];
      lin_comp_o            <= CTRL_RST[`DCR_LIN_HI:`DCR_LIN_LO];
    end
    else
    begin
      dac_code_o            <= next_output_code[`DCR_CODE_HI:`DCR_CODE_LO];
      amp_powered_o         <= !next_amp;
      fb_parallel_o         <= next_amp;
      output_ground_clamp_o <= next_clamp;
      converter_tristate_o  <= next_tri;
      code_format_sel_o     <= next_mode_control[`DCR_BIT_FMT];
      serial_out_disable_o  <= next_mode_control[`DCR_BIT_SDO];
      lin_comp_o            <= next_mode_control[`DCR_LIN_HI:`DCR_LIN_LO];
    end
  end

  // The stored words go out as they are.
  assign output_code_o  = output_code;
  assign mode_control_o = mode_control;
endmodule

// file: hw/dcr_params.svh
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

// Frame layout: 24 bits, MSB first.
`define DCR_FRAME_W        24
`define DCR_RW_BIT         23
`define DCR_ADDR_HI        22
`define DCR_ADDR_LO        20
`define DCR_DATA_HI        19
`define DCR_DATA_LO        0
`define DCR_DATA_W         20

// Register addresses.
`define DCR_ADDR_CODE      3'h1
`define DCR_ADDR_CTRL      3'h2

// Code field position inside the data field.
`define DCR_CODE_HI        19
`define DCR_CODE_LO        2
`define DCR_CODE_W         18

// Control field positions.
`define DCR_BIT_AMP        1
`define DCR_BIT_CLAMP      2
`define DCR_BIT_TRI        3
`define DCR_BIT_FMT        4
`define DCR_BIT_SDO        5
`define DCR_LIN_HI         9
`define DCR_LIN_LO         6
`define DCR_LIN_W          4

// Reset values.
`define DCR_CODE_RST       20'h00000
`define DCR_CTRL_RST       20'h0000e

`endif

// file: hw/dcr_pkg.sv
package dcr_pkg;
  typedef logic [19:0] dcr_word_t;
  typedef logic [2:0]  dcr_addr_t;
endpackage

// file: hw/dcr_frame_rx.sv
`timescale 1ns/1ps
`include "dcr_params.svh"

// Shifts one framed word in and flags a frame that held exactly the right bit count.
module dcr_frame_rx #(
  parameter int FRAME_W = `DCR_FRAME_W
) (
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               frame_active_i,
  input  wire logic               bit_valid_i,
  input  wire logic               bit_data_i,
  output logic                    frame_done_o,
  output logic [FRAME_W-1:0]      frame_word_o
);
  // Refuse lengths that the 8-bit counter cannot hold or that leave no room to shift.
  if (FRAME_W < 2 || FRAME_W > 255)
  begin : g_bad_width
    $error("FRAME_W out of range");
  end

  logic [FRAME_W-1:0] shift;
  logic [7:0]         count;
  logic               active_q;
  logic               over;
  wire                frame_end = active_q && !frame_active_i;
  wire                count_ok  = (count == 8'(FRAME_W)) && !over;

  // Count and shift bits while the frame is open; a count past the length poisons it.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      shift        <= '0;
      count        <= 8'h00;
      active_q     <= 1'b0;
      over         <= 1'b0;
      frame_done_o <= 1'b0;
      frame_word_o <= '0;
    end
    else
    begin
      active_q     <= frame_active_i;
      frame_done_o <= frame_end && count_ok;
      if (frame_end && count_ok)
        frame_word_o <= shift;
      if (!frame_active_i)
      begin
        count <= 8'h00;
        over  <= 1'b0;
      end
      else if (bit_valid_i)
      begin
        shift <= {shift[FRAME_W-2:0], bit_data_i};
        if (count == 8'(FRAME_W))
          over <= 1'b1; // Too many bits makes the frame invalid.
        else
          count <= count + 8'h01;
      end
    end
  end
endmodule

// file: verification/dcr_regs_sva.sv
`timescale 1ns/1ps
// Watches the register outputs; a write may change them only together with the done strobe.
module dcr_regs_sva
(
  input  wire logic          mclk_i,
  input  wire logic          sys_rst_i,
  input  dcr_pkg::dcr_word_t output_code_o,
  input  dcr_pkg::dcr_word_t mode_control_o,
  input  wire logic [17:0]   dac_code_o,
  input  wire logic          amp_powered_o,
  input  wire logic          fb_parallel_o,
  input  wire logic          output_ground_clamp_o,
  input  wire logic          converter_tristate_o,
  input  wire logic          code_format_sel_o,
  input  wire logic          serial_out_disable_o,
  input  wire logic [3:0]    lin_comp_o,
  input  wire logic          write_done_o
);
  import dcr_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Decoded outputs are tied to the stored fields at every edge.
  property p_code; dac_code_o == output_code_o[19:2] && output_code_o[1:0] == 2'h0; endproperty
  a_code: assert property (p_code) else $error("code out");
  property p_amp;
    amp_powered_o == !mode_control_o[1] && fb_parallel_o == mode_control_o[1];
  endproperty
  a_amp: assert property (p_amp) else $error("amp out");
  property p_clamp; output_ground_clamp_o == mode_control_o[2]; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp out");
  property p_tri; converter_tristate_o == (mode_control_o[2] | mode_control_o[3]); endproperty
  a_tri: assert property (p_tri) else $error("tristate out");
  property p_rsv; mode_control_o[19:10] == 10'h000 && !mode_control_o[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  // The plain field pins follow their stored bits at every edge.
  property p_fld;
    code_format_sel_o == mode_control_o[4] && serial_out_disable_o == mode_control_o[5] &&
      lin_comp_o == mode_control_o[9:6];
  endproperty
  a_fld: assert property (p_fld) else $error("field out");
  property p_rst;
    $fell(sys_rst_i) |-> mode_control_o == 20'h0000e && output_ground_clamp_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_upd; !$stable(mode_control_o) || !$stable(output_code_o) |-> write_done_o; endproperty
  a_upd: assert property (p_upd) else $error("stray update");
  property p_done; write_done_o |=> !write_done_o; endproperty
  a_done: assert property (p_done) else $error("long strobe");
  c_done: cover property (write_done_o);
  c_live: cover property (!converter_tristate_o);
  c_amp: cover property (amp_powered_o);
endmodule
bind dcr_regs dcr_regs_sva u_sva (
  .mclk_i                (mclk_i),
  .sys_rst_i             (sys_rst_i),
  .output_code_o         (output_code_o),
  .mode_control_o        (mode_control_o),
  .dac_code_o            (dac_code_o),
  .amp_powered_o         (amp_powered_o),
  .fb_parallel_o         (fb_parallel_o),
  .output_ground_clamp_o (output_ground_clamp_o),
  .converter_tristate_o  (converter_tristate_o),
  .code_format_sel_o     (code_format_sel_o),
  .serial_out_disable_o  (serial_out_disable_o),
  .lin_comp_o            (lin_comp_o),
  .write_done_o          (write_done_o)
);

// file: verification/dcr_host.sv
`timescale 1ns/1ps
// Serial host model; the bit count is an argument so that short and long frames can be sent.
module dcr_host (
  input  wire logic mclk_i,
  output logic      frame_active_o,
  output logic      bit_valid_o,
  output logic      bit_data_o
);
  initial
  begin
    frame_active_o = 1'b0;
    bit_valid_o = 1'b0;
    bit_data_o = 1'b0;
  end
  // Idle data shows the inverse of the last bit so a stale value is never read as good.
  task automatic send(input logic [23:0] w, input int n);
    for (int i = 0; i < n + 2; i++)
    begin
      @(posedge mclk_i) #1;
      frame_active_o = (i <= n);
      bit_valid_o = (i > 0 && i <= n);
      bit_data_o = bit_valid_o ? w[(48 - i) % 24] : ~bit_data_o;
    end
  endtask
endmodule

// file: verification/tb_dcr_regs.sv
`timescale 1ns/1ps
module tb_dcr_regs;
  import dcr_pkg::*;
  logic mclk_i, sys_rst_i, frame_active_i, bit_valid_i, bit_data_i;
  logic amp_powered_o, fb_parallel_o, output_ground_clamp_o, converter_tristate_o;
  logic code_format_sel_o, serial_out_disable_o, write_done_o;
  dcr_word_t output_code_o, mode_control_o;
  logic [17:0] dac_code_o;
  logic [3:0] lin_comp_o;
  wire [2:0] out_state = {converter_tristate_o, output_ground_clamp_o, fb_parallel_o};
  int err_total = 0;
  int tests_run = 0;
  dcr_regs u_dut (
    .mclk_i                (mclk_i),
    .sys_rst_i             (sys_rst_i),
    .frame_active_i        (frame_active_i),
    .bit_valid_i           (bit_valid_i),
    .bit_data_i            (bit_data_i),
    .output_code_o         (output_code_o),
    .mode_control_o        (mode_control_o),
    .dac_code_o            (dac_code_o),
    .amp_powered_o         (amp_powered_o),
    .fb_parallel_o         (fb_parallel_o),
    .output_ground_clamp_o (output_ground_clamp_o),
    .converter_tristate_o  (converter_tristate_o),
    .code_format_sel_o     (code_format_sel_o),
    .serial_out_disable_o  (serial_out_disable_o),
    .lin_comp_o            (lin_comp_o),
    .write_done_o          (write_done_o)
  );
  dcr_host u_host (.mclk_i, .frame_active_o(frame_active_i), .bit_valid_o(bit_valid_i),
                   .bit_data_o(bit_data_i));
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A missing strobe ends the run, since every later check would be off.
  task automatic wr(input logic [23:0] w, input int n, input logic ok);
    logic seen;
    seen = 1'b0;
    u_host.send(w, n);
    repeat (4)
    begin
      @(posedge mclk_i) #1;
      seen |= write_done_o;
    end
    chk(20'(seen), 20'(ok));
    if (ok && !seen) tally_and_finish();
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // Reset, one legal code write and three legal control writes, then refused frames and a second reset.
  initial
  begin
    sys_rst_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    chk(mode_control_o, 20'h0000e);
    chk(20'({converter_tristate_o, output_ground_clamp_o, fb_parallel_o}), 20'h7);
    $display("reset test end");
    wr(24'h1fffff, 24, 1'b1);
    chk(output_code_o, 20'hffffc);
    chk(20'(dac_code_o), 20'h3ffff);
    wr(24'h200274, 24, 1'b1);
    chk(20'({converter_tristate_o, amp_powered_o, lin_comp_o, serial_out_disable_o,
             code_format_sel_o}), 20'he7);
    chk(mode_control_o, 20'h00274);
    wr(24'h200008, 24, 1'b1);
    chk(20'(out_state), 20'h4);
    wr(24'h200000, 24, 1'b1);
    chk(20'(out_state), 20'h0);
    $display("write test end");
    wr(24'h112345, 23, 1'b0);
    wr(24'h112345, 25, 1'b0);
    wr(24'h912345, 24, 1'b0);
    wr(24'h312345, 24, 1'b0);
    chk(output_code_o, 20'hffffc);
    chk(mode_control_o, 20'h00000);
    $display("refuse test end");
    sys_rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    chk(mode_control_o, 20'h0000e);
    chk(output_code_o, 20'h00000);
    $display("rerun reset test end");
    tally_and_finish();
  end
endmodule
